// [src/fpsc_ctrl.sv]
// flash protection override, interrupts, stop handshake and security logic
`timescale 1ns/1ns
// Notes on behaviour
// - override launch saves both protection registers
// - restore reloads saved pair, direct writes lost
// - restore never forces reset values
// - access error unless index 1, 2 or 3
// - access error when command unavailable in mode
// - access error restoring with nothing saved
// - access error: selection 00, index 2/3
// - access error: selection 00, index 1, valid key
// - command irq when complete flag and enable
// - error irq when single fault and enable
// - unaffected in wait, complete irq wakes
// - stop waits for active command to finish
// - security register loaded at reset from byte
// - new security byte only after next reset
// - verify four backdoor keys, unsecure on match
// - match forces security field to 10
// - keys 0000 and ffff never match
// - flash reads refused during key verify
// - failed verify locks out until reset
// - backdoor leaves stored bytes and pflash protection
// - match saves, updates selected, sets override bit
// - mismatch or ffff restores, clears override bit
module fpsc_ctrl import fpsc_pkg::*; #(
    parameter int VERIFY_LEN = VERIFY_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [7:0] CFG_SEC_BYTE,
    input wire logic [7:0] CFG_PPROT,
    input wire logic [7:0] CFG_DPROT,
    input wire logic [15:0] CFG_OVRD_KEY,
    input wire logic [63:0] CFG_BACKDOOR_KEYS,
    input wire logic OVRD_AVAIL,
    input wire logic ECC_SINGLE_FAULT,
    input wire logic STOP_REQ,
    output logic STOP_ACK,
    output logic CMD_IRQ,
    output logic ERR_IRQ,
    output logic FLASH_RD_BLOCK
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    localparam int CW = $clog2(VERIFY_LEN + 1);

    typedef struct packed {
        fpsc_state_t st;
        logic command_complete_flag;
        logic access_error_flag;
        logic protect_violation_flag;
        logic command_complete_irq_en;
        logic single_fault_flag;
        logic single_fault_irq_en;
        logic [2:0] idx;
        logic [NUM_PARAMS-1:0][15:0] prm;
        logic [7:0] pprot;
        logic [7:0] dprot;
        logic [7:0] sv_pprot;
        logic [7:0] sv_dprot;
        logic ovrd;
        logic [7:0] sec;
        logic lock;
        logic [CW-1:0] cnt;
        logic ack;
        logic [31:0] dat;
        logic cmd_irq;
        logic err_irq;
        logic rd_block;
        logic stop_ack;
    } fpsc_regs_t;

    fpsc_regs_t r_q;
    fpsc_regs_t r_d;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // zero and erased keys never qualify, even if stored that way
    function automatic logic key_ok(input logic [15:0] given,
                                    input logic [15:0] stored);
        key_ok = (given == stored) && (given != KEY_ZERO) &&
                 (given != KEY_ERASED);
    endfunction : key_ok

    logic wb_req;
    logic wb_wr;
    logic [2:0] pidx;
    logic [15:0] okey;
    logic [1:0] osel;
    logic key_valid;
    logic key_match;
    logic ovrd_err;
    logic keys_hit;

    assign wb_req = WB_CYC_I & WB_STB_I & ~r_q.ack;
    assign wb_wr = wb_req & WB_WE_I;
    assign pidx = (r_q.idx < 3'(NUM_PARAMS)) ? r_q.idx : 3'h0;
    assign okey = r_q.prm[1];
    assign osel = r_q.prm[0][1:0];
    assign key_valid = (okey != KEY_ERASED);
    // an erased stored key disables override for good
    assign key_match = key_valid && (CFG_OVRD_KEY != KEY_ERASED) &&
                       (okey == CFG_OVRD_KEY);

    always_comb begin
        ovrd_err = 1'b0;
        if (!OVRD_AVAIL) begin
            ovrd_err = 1'b1;
        end
        if (r_q.idx != IDX_ONE && r_q.idx != IDX_TWO &&
            r_q.idx != IDX_THREE) begin
            ovrd_err = 1'b1;
        end
        if (!key_match && !r_q.ovrd) begin
            ovrd_err = 1'b1;
        end
        if (osel == SEL_NONE &&
            (r_q.idx == IDX_TWO || r_q.idx == IDX_THREE)) begin
            ovrd_err = 1'b1;
        end
        if (osel == SEL_NONE && r_q.idx == IDX_ONE && key_valid) begin
            ovrd_err = 1'b1;
        end
    end

    assign keys_hit =
        key_ok(r_q.prm[1], CFG_BACKDOOR_KEYS[63:48]) &&
        key_ok(r_q.prm[2], CFG_BACKDOOR_KEYS[47:32]) &&
        key_ok(r_q.prm[3], CFG_BACKDOOR_KEYS[31:16]) &&
        key_ok(r_q.prm[4], CFG_BACKDOOR_KEYS[15:0]);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.ack = wb_req;
        r_d.dat = 32'h0000_0000;

        // --------------------------------------------------------------
        // bus writes; clears come first so hardware sets below win
        // --------------------------------------------------------------
        if (wb_wr && WB_SEL_I[0]) begin
            case (WB_ADR_I)
                OFS_CMD_STATUS: begin
                    if (WB_DAT_I[BIT_ACCESS_ERROR_FLAG]) begin
                        r_d.access_error_flag = 1'b0;
                    end
                    if (WB_DAT_I[BIT_PROTECT_VIOLATION_FLAG]) begin
                        r_d.protect_violation_flag = 1'b0;
                    end
                    // launch only from a clean idle status
                    if (WB_DAT_I[BIT_COMMAND_COMPLETE_FLAG] && r_q.command_complete_flag &&
                        r_q.st == ST_IDLE && !r_q.access_error_flag &&
                        !r_q.protect_violation_flag) begin
                        r_d.command_complete_flag = 1'b0;
                        r_d.st = ST_EXEC;
                    end
                end
                OFS_CMD_CONFIG: begin
                    r_d.command_complete_irq_en = WB_DAT_I[BIT_COMMAND_COMPLETE_IRQ_EN];
                end
                OFS_ERR_STATUS: begin
                    if (WB_DAT_I[BIT_SINGLE_FAULT_FLAG]) begin
                        r_d.single_fault_flag = 1'b0;
                    end
                end
                OFS_ERR_CONFIG: begin
                    r_d.single_fault_irq_en = WB_DAT_I[BIT_SINGLE_FAULT_IRQ_EN];
                end
                OFS_PARAM_INDEX: begin
                    r_d.idx = WB_DAT_I[2:0];
                end
                OFS_PARAM_DATA: begin
                    r_d.prm[pidx][7:0] = WB_DAT_I[7:0];
                    if (WB_SEL_I[1]) begin
                        r_d.prm[pidx][15:8] = WB_DAT_I[15:8];
                    end
                end
                OFS_PFLASH_PROT: begin
                    r_d.pprot = WB_DAT_I[7:0];
                end
                OFS_DFLASH_PROT: begin
                    r_d.dprot = WB_DAT_I[7:0];
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------------
        // bus reads, answered with the ack
        // --------------------------------------------------------------
        if (wb_req && !WB_WE_I) begin
            case (WB_ADR_I)
                OFS_CMD_STATUS: begin
                    r_d.dat[BIT_COMMAND_COMPLETE_FLAG] = r_q.command_complete_flag;
                    r_d.dat[BIT_ACCESS_ERROR_FLAG] = r_q.access_error_flag;
                    r_d.dat[BIT_PROTECT_VIOLATION_FLAG] = r_q.protect_violation_flag;
                end
                OFS_CMD_CONFIG: begin
                    r_d.dat[BIT_COMMAND_COMPLETE_IRQ_EN] = r_q.command_complete_irq_en;
                end
                OFS_ERR_STATUS: begin
                    r_d.dat[BIT_SINGLE_FAULT_FLAG] = r_q.single_fault_flag;
                end
                OFS_ERR_CONFIG: begin
                    r_d.dat[BIT_SINGLE_FAULT_IRQ_EN] = r_q.single_fault_irq_en;
                end
                OFS_PARAM_INDEX: begin
                    r_d.dat[2:0] = r_q.idx;
                end
                OFS_PARAM_DATA: begin
                    r_d.dat[15:0] = r_q.prm[pidx];
                end
                OFS_PFLASH_PROT: begin
                    r_d.dat[7:0] = r_q.pprot;
                end
                OFS_DFLASH_PROT: begin
                    r_d.dat[7:0] = r_q.dprot;
                end
                OFS_PROT_STATUS: begin
                    r_d.dat[BIT_OVRD] = r_q.ovrd;
                end
                OFS_SECURITY: begin
                    r_d.dat[7:0] = r_q.sec;
                end
                default: begin
                    r_d.dat = 32'h0000_0000;
                end
            endcase
        end

        // --------------------------------------------------------------
        // ecc single fault; a set beats a clear in the same cycle
        // --------------------------------------------------------------
        if (ECC_SINGLE_FAULT) begin
            r_d.single_fault_flag = 1'b1;
        end

        // --------------------------------------------------------------
        // command sequencing; unaffected by wait mode
        // --------------------------------------------------------------
        case (r_q.st)
            ST_INIT: begin
                // straps are sampled only here, after reset release
                r_d.sec = CFG_SEC_BYTE;
                r_d.pprot = CFG_PPROT;
                r_d.dprot = CFG_DPROT;
                r_d.command_complete_flag = 1'b1;
                r_d.st = ST_IDLE;
            end
            ST_IDLE: begin
            end
            ST_EXEC: begin
                r_d.st = ST_IDLE;
                r_d.command_complete_flag = 1'b1;
                if (r_q.prm[0][15:8] == CMD_PROT_OVRD) begin
                    if (ovrd_err) begin
                        r_d.access_error_flag = 1'b1;
                    end else if (key_match) begin
                        r_d.sv_pprot = r_q.pprot;
                        r_d.sv_dprot = r_q.dprot;
                        if (osel[0] && r_q.idx >= IDX_TWO) begin
                            r_d.pprot = r_q.prm[2][7:0];
                        end
                        if (osel[1] && r_q.idx >= IDX_THREE) begin
                            r_d.dprot = r_q.prm[3][7:0];
                        end
                        r_d.ovrd = 1'b1;
                    end else begin
                        // saved pair, never reset values
                        r_d.pprot = r_q.sv_pprot;
                        r_d.dprot = r_q.sv_dprot;
                        r_d.ovrd = 1'b0;
                    end
                end else if (r_q.prm[0][15:8] == CMD_VERIFY_KEY) begin
                    if (r_q.lock || r_q.idx != IDX_FOUR ||
                        r_q.sec[BACKDOOR_ENABLE_FIELD_LSB+:2] != BACKDOOR_ENABLE_FIELD_ON) begin
                        r_d.access_error_flag = 1'b1;
                    end else begin
                        r_d.command_complete_flag = 1'b0;
                        r_d.st = ST_VERIFY;
                        r_d.cnt = CW'(VERIFY_LEN - 1);
                        r_d.rd_block = 1'b1;
                    end
                end
            end
            ST_VERIFY: begin
                if (r_q.cnt != '0) begin
                    r_d.cnt = r_q.cnt - 1'b1;
                end else begin
                    r_d.st = ST_IDLE;
                    r_d.command_complete_flag = 1'b1;
                    r_d.rd_block = 1'b0;
                    // only the live field moves; stored bytes stay
                    if (keys_hit) begin
                        r_d.sec[SEC_LSB+:2] = SEC_UNSECURE;
                    end else begin
                        r_d.lock = 1'b1;
                        r_d.access_error_flag = 1'b1;
                    end
                    // pflash protection untouched here
                end
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase

        // --------------------------------------------------------------
        // level requests, registered in the same cycle as the flags
        // --------------------------------------------------------------
        r_d.cmd_irq = r_d.command_complete_flag & r_d.command_complete_irq_en;
        r_d.err_irq = r_d.single_fault_flag & r_d.single_fault_irq_en;
        // stop granted only with no command in flight
        r_d.stop_ack = STOP_REQ & r_d.command_complete_flag & (r_d.st == ST_IDLE);
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r_q.st <= ST_INIT;
            r_q.command_complete_flag <= 1'b0;
            r_q.access_error_flag <= 1'b0;
            r_q.protect_violation_flag <= 1'b0;
            r_q.command_complete_irq_en <= 1'b0;
            r_q.single_fault_flag <= 1'b0;
            r_q.single_fault_irq_en <= 1'b0;
            r_q.idx <= 3'h0;
            r_q.prm <= '0;
            r_q.pprot <= RST_PROT;
            r_q.dprot <= RST_PROT;
            r_q.sv_pprot <= RST_PROT;
            r_q.sv_dprot <= RST_PROT;
            r_q.ovrd <= 1'b0;
            r_q.sec <= RST_SEC;
            r_q.lock <= 1'b0;
            r_q.cnt <= '0;
            r_q.ack <= 1'b0;
            r_q.dat <= 32'h0000_0000;
            r_q.cmd_irq <= 1'b0;
            r_q.err_irq <= 1'b0;
            r_q.rd_block <= 1'b0;
            r_q.stop_ack <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    assign WB_DAT_O = r_q.dat;
    assign WB_ACK_O = r_q.ack;
    assign STOP_ACK = r_q.stop_ack;
    assign CMD_IRQ = r_q.cmd_irq;
    assign ERR_IRQ = r_q.err_irq;
    assign FLASH_RD_BLOCK = r_q.rd_block;
endmodule : fpsc_ctrl

// [src/fpsc_pkg.sv]
// constants and types shared by the flash protection/security control block
package fpsc_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CMD_STATUS = 8'h00;
    localparam logic [7:0] OFS_CMD_CONFIG = 8'h04;
    localparam logic [7:0] OFS_ERR_STATUS = 8'h08;
    localparam logic [7:0] OFS_ERR_CONFIG = 8'h0c;
    localparam logic [7:0] OFS_PARAM_INDEX = 8'h10;
    localparam logic [7:0] OFS_PARAM_DATA = 8'h14;
    localparam logic [7:0] OFS_PFLASH_PROT = 8'h18;
    localparam logic [7:0] OFS_DFLASH_PROT = 8'h1c;
    localparam logic [7:0] OFS_PROT_STATUS = 8'h20;
    localparam logic [7:0] OFS_SECURITY = 8'h24;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_COMMAND_COMPLETE_FLAG = 7;
    localparam int BIT_ACCESS_ERROR_FLAG = 5;
    localparam int BIT_PROTECT_VIOLATION_FLAG = 4;
    localparam int BIT_COMMAND_COMPLETE_IRQ_EN = 7;
    localparam int BIT_SINGLE_FAULT_FLAG = 0;
    localparam int BIT_SINGLE_FAULT_IRQ_EN = 0;
    localparam int BIT_OVRD = 0;
    localparam int SEC_LSB = 0;
    localparam int BACKDOOR_ENABLE_FIELD_LSB = 6;
    // ------------------------------------------------------------------
    // command codes, indices, encodings
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_VERIFY_KEY = 8'h0c;
    localparam logic [7:0] CMD_PROT_OVRD = 8'h13;
    localparam logic [2:0] IDX_ONE = 3'h1;
    localparam logic [2:0] IDX_TWO = 3'h2;
    localparam logic [2:0] IDX_THREE = 3'h3;
    localparam logic [2:0] IDX_FOUR = 3'h4;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEC_UNSECURE = 2'h2;
    localparam logic [1:0] BACKDOOR_ENABLE_FIELD_ON = 2'h2;
    localparam logic [15:0] KEY_ERASED = 16'hffff;
    localparam logic [15:0] KEY_ZERO = 16'h0000;
    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PROT = 8'h00;
    localparam logic [7:0] RST_SEC = 8'h00;
    localparam int CLK_PERIOD_NS = 4;
    localparam int VERIFY_TIME_NS = 40;
    localparam int VERIFY_CYCLES =
        (VERIFY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NUM_PARAMS = 6;
    // ------------------------------------------------------------------
    // control states, gray along init-idle-exec-verify
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_INIT = 2'h0,
        ST_IDLE = 2'h1,
        ST_EXEC = 2'h3,
        ST_VERIFY = 2'h2
    } fpsc_state_t;
endpackage : fpsc_pkg

// [sim/fpsc_ctrl_properties.sv]
// port assertions for the protection and security control block
`timescale 1ns/1ns
module fpsc_chk #(
    parameter int VERIFY_LEN = 10
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic ECC_SINGLE_FAULT,
    input wire logic STOP_REQ,
    input wire logic STOP_ACK,
    input wire logic CMD_IRQ,
    input wire logic ERR_IRQ,
    input wire logic FLASH_RD_BLOCK
);
    // ----------------------------------------------------------------
    // helper: cycles spent with reads blocked
    // ----------------------------------------------------------------
    logic [7:0] blk_q;
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            blk_q <= 8'h00;
        end else begin
            blk_q <= FLASH_RD_BLOCK ? blk_q + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_ack_after_req: assert property (
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acked");
    a_ack_one_cycle: assert property (
        WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
    a_ack_has_cause: assert property (
        $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    a_block_length: assert property (
        $fell(FLASH_RD_BLOCK) |-> blk_q == VERIFY_LEN)
        else $error("read block window wrong length");
    a_stop_held_off: assert property (
        FLASH_RD_BLOCK && $past(FLASH_RD_BLOCK) |-> !STOP_ACK)
        else $error("stop granted during active command");
    a_stop_needs_req: assert property (
        !STOP_REQ |=> !STOP_ACK) else $error("stop ack without request");
    a_cmd_irq_quiet: assert property (
        FLASH_RD_BLOCK |-> !CMD_IRQ)
        else $error("command irq while command active");
    a_err_irq_cause: assert property (
        $rose(ERR_IRQ) |-> $past(ECC_SINGLE_FAULT) || WB_ACK_O)
        else $error("error irq without fault or enable write");
endmodule : fpsc_chk
bind fpsc_ctrl fpsc_chk #(.VERIFY_LEN(VERIFY_LEN)) u_chk (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O),
    .ECC_SINGLE_FAULT(ECC_SINGLE_FAULT), .STOP_REQ(STOP_REQ),
    .STOP_ACK(STOP_ACK), .CMD_IRQ(CMD_IRQ), .ERR_IRQ(ERR_IRQ),
    .FLASH_RD_BLOCK(FLASH_RD_BLOCK));

// [sim/fpsc_flash_model.sv]
// partner model: flash configuration field and corrected-read source
`timescale 1ns/1ns
module fpsc_flash_model #(
    parameter logic [7:0] SEC_INIT = 8'h83,
    parameter logic [7:0] PPROT_INIT = 8'h84,
    parameter logic [7:0] DPROT_INIT = 8'h21,
    parameter logic [15:0] OKEY_INIT = 16'h5a3c,
    parameter logic [63:0] KEYS_INIT = 64'h1111_2222_3333_4444
) (
    input wire logic clk,
    input wire logic fault_req,
    output logic [7:0] sec_byte,
    output logic [7:0] pprot,
    output logic [7:0] dprot,
    output logic [15:0] ovrd_key,
    output logic [63:0] bd_keys,
    output logic fault_pulse
);
    // ----------------------------------------------------------------
    // stored bytes, changed only by reprogramming from the bench
    // ----------------------------------------------------------------
    initial begin
        sec_byte = SEC_INIT;
        pprot = PPROT_INIT;
        dprot = DPROT_INIT;
        ovrd_key = OKEY_INIT;
        bd_keys = KEYS_INIT;
        fault_pulse = 1'b0;
    end
    // one pulse per corrected read, same clock as the block
    always @(posedge clk) begin
        fault_pulse <= fault_req;
    end
endmodule : fpsc_flash_model

// [sim/testbench.sv]
// self-checking bench for the protection and security control block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    mismatches++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench import fpsc_pkg::*;;
    localparam int VLEN = 2;
    localparam logic [15:0] OKEY = 16'h5a3c;
    logic core_clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic we = 1'b0, ovrd_avail = 1'b1, fault_req = 1'b0, stop_req = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat_o;
    logic ack, stop_ack, cmd_irq, err_irq, rd_blk, ecc, stop_bad = 1'b0;
    logic [7:0] sec_b, pprot, dprot;
    logic [15:0] okey;
    logic [63:0] bkeys;
    logic [15:0] prm [0:4];
    int mismatches = 0, check_count = 0, blk_n = 0;
    always #2 core_clk = ~core_clk;
    fpsc_flash_model u_flash (.clk(core_clk), .fault_req(fault_req),
        .sec_byte(sec_b), .pprot(pprot), .dprot(dprot), .ovrd_key(okey),
        .bd_keys(bkeys), .fault_pulse(ecc));
    fpsc_ctrl #(.VERIFY_LEN(VLEN)) uut (.CORE_CLK(core_clk),
        .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .CFG_SEC_BYTE(sec_b), .CFG_PPROT(pprot),
        .CFG_DPROT(dprot), .CFG_OVRD_KEY(okey), .CFG_BACKDOOR_KEYS(bkeys),
        .OVRD_AVAIL(ovrd_avail), .ECC_SINGLE_FAULT(ecc),
        .STOP_REQ(stop_req), .STOP_ACK(stop_ack), .CMD_IRQ(cmd_irq),
        .ERR_IRQ(err_irq), .FLASH_RD_BLOCK(rd_blk));
    // blocked-read window length and stop grants inside it
    always @(posedge core_clk) begin
        if (rd_blk === 1'b1) begin
            blk_n++;
            if (stop_ack === 1'b1 && blk_n > 1) stop_bad = 1'b1;
        end
    end
    // ----------------------------------------------------------------
    // bus and command helpers
    // ----------------------------------------------------------------
    task give_verdict;
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin @(posedge core_clk); n++; end
        while (ack !== 1'b1 && n < 50);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) begin mismatches++; give_verdict(); end
    endtask : wb
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task rchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        `CHK(nm, e, q[7:0])
    endtask : rchk
    // polls completion; a slow command is bounded, never open-ended
    task run(input logic [2:0] last);
        logic [31:0] q;
        int n;
        for (int i = 0; i < 5; i++) begin
            wr(OFS_PARAM_INDEX, 32'(i));
            wr(OFS_PARAM_DATA, {16'h0000, prm[i]});
        end
        wr(OFS_PARAM_INDEX, {29'h0, last});
        wr(OFS_CMD_STATUS, 32'h80);
        n = 0;
        do begin wb(1'b0, OFS_CMD_STATUS, 32'h0, q); n++; end
        while (q[BIT_COMMAND_COMPLETE_FLAG] !== 1'b1 && n < 40);
        if (n >= 40) begin mismatches++; give_verdict(); end
    endtask : run
    task err_case(input logic [2:0] last, input string nm);
        run(last);
        rchk(OFS_CMD_STATUS, 8'ha0, nm);
        rchk(OFS_PFLASH_PROT, 8'hff, nm);
        wr(OFS_CMD_STATUS, 32'h20);
    endtask : err_case
    task do_reset;
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask : do_reset
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task sc_security;
        rchk(OFS_SECURITY, 8'h83, "sec_reset");
        @(posedge core_clk);
        u_flash.sec_byte <= 8'h81;
        rchk(OFS_SECURITY, 8'h83, "sec_early");
        do_reset();
        rchk(OFS_SECURITY, 8'h81, "sec_next");
    endtask : sc_security
    task sc_verify_ok;
        @(posedge core_clk);
        stop_req <= 1'b1;
        blk_n = 0;
        wr(OFS_CMD_CONFIG, 32'h80);
        prm = '{16'h0c00, 16'h1111, 16'h2222, 16'h3333, 16'h4444};
        run(3'h4);
        `CHK("blk_len", VLEN, blk_n)
        `CHK("stop_hold", 1'b0, stop_bad)
        `CHK("stop_ack", 1'b1, stop_ack)
        `CHK("cmd_irq_done", 1'b1, cmd_irq)
        rchk(OFS_SECURITY, 8'h82, "unsecure");
        rchk(OFS_PFLASH_PROT, 8'h84, "pprot_kept");
        wr(OFS_CMD_CONFIG, 32'h0);
        @(posedge core_clk);
        stop_req <= 1'b0;
    endtask : sc_verify_ok
    task sc_override;
        prm = '{16'h1303, OKEY, 16'h00ff, 16'h0011, 16'h0000};
        run(3'h3);
        rchk(OFS_PFLASH_PROT, 8'hff, "ovr_p");
        rchk(OFS_DFLASH_PROT, 8'h11, "ovr_d");
        rchk(OFS_PROT_STATUS, 8'h01, "ovr_on");
        prm = '{16'h1301, OKEY, 16'h0077, 16'h0000, 16'h0000};
        run(3'h2);
        rchk(OFS_PFLASH_PROT, 8'h77, "ovr2_p");
        wr(OFS_DFLASH_PROT, 32'h66);
        prm[1] = 16'hffff;
        run(3'h1);
        rchk(OFS_PFLASH_PROT, 8'hff, "rest_p");
        rchk(OFS_DFLASH_PROT, 8'h11, "rest_d");
        rchk(OFS_PROT_STATUS, 8'h00, "ovr_off");
        prm = '{16'h1303, 16'h1234, 16'h0000, 16'h0000, 16'h0000};
        err_case(3'h1, "no_saved");
        prm = '{16'h1300, OKEY, 16'h0000, 16'h0000, 16'h0000};
        err_case(3'h1, "sel0_key");
        err_case(3'h2, "sel0_i2");
        err_case(3'h3, "sel0_i3");
        prm[0] = 16'h1303;
        err_case(3'h0, "index0");
        err_case(3'h4, "index4");
        err_case(3'h5, "index5");
        @(posedge core_clk);
        ovrd_avail <= 1'b0;
        err_case(3'h3, "mode");
        @(posedge core_clk);
        ovrd_avail <= 1'b1;
    endtask : sc_override
    task sc_irq;
        wr(OFS_CMD_CONFIG, 32'h80);
        repeat (2) @(posedge core_clk);
        `CHK("cmd_irq_on", 1'b1, cmd_irq)
        wr(OFS_CMD_CONFIG, 32'h0);
        repeat (2) @(posedge core_clk);
        `CHK("cmd_irq_off", 1'b0, cmd_irq)
        wr(OFS_ERR_CONFIG, 32'h1);
        @(posedge core_clk);
        fault_req <= 1'b1;
        @(posedge core_clk);
        fault_req <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK("err_irq_on", 1'b1, err_irq)
        wr(OFS_ERR_STATUS, 32'h1);
        repeat (2) @(posedge core_clk);
        `CHK("err_irq_off", 1'b0, err_irq)
    endtask : sc_irq
    task sc_lockout;
        do_reset();
        @(posedge core_clk);
        u_flash.bd_keys <= 64'h0000_2222_3333_4444;
        prm = '{16'h0c00, 16'h0000, 16'h2222, 16'h3333, 16'h4444};
        run(3'h4);
        rchk(OFS_SECURITY, 8'h81, "zero_key");
        wr(OFS_CMD_STATUS, 32'h20);
        @(posedge core_clk);
        u_flash.bd_keys <= 64'h1111_2222_3333_4444;
        prm[1] = 16'h1111;
        run(3'h4);
        rchk(OFS_CMD_STATUS, 8'ha0, "lock_err");
        rchk(OFS_SECURITY, 8'h81, "locked");
    endtask : sc_lockout
    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        sc_security();
        sc_verify_ok();
        sc_override();
        sc_irq();
        sc_lockout();
        give_verdict();
    end
endmodule : testbench
